// >>> dv/mdf_framer_properties.sv
`timescale 1ns/10ps
module mdf_framer_checker
    import mdf_pkg::*;
#(
    parameter int PKT_OCTETS = 8
)
(
    // Clock and reset
    input wire logic        clk,
    input wire logic        reset,
    // Register bus
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Radio transmit
    input wire logic        tx_data,
    input wire logic        tx_active,
    input wire logic        tx_frame_end
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    // Bus answers and decode
    pready_hi_a:
        assert property (psel |-> pready) else $error("pready low");
    unmapped_err_a:
        assert property (psel && penable && paddr > REG_ACK_INFL |-> pslverr) else $error("no error flag");
    mapped_ok_a:
        assert property (psel && penable && paddr <= REG_ACK_INFL && paddr[1:0] == 2'h0 |-> !pslverr)
            else $error("false error flag");
    // Dwell class picks exactly one ack method
    ack_long_a:
        assert property (psel && !penable && !pwrite && paddr == REG_STATUS
            |=> prdata[ST_ACK_MD] != prdata[ST_LONG] && prdata[31:8] == 24'h0) else $error("bad status");
    // Frame opens with the low sync bits, all zero
    sync_first_a:
        assert property ($rose(tx_active) |-> (!tx_data) [*4]) else $error("bad sync start");
    frame_hold_a:
        assert property ($rose(tx_active) |-> tx_active [*8]) else $error("frame gap");
    // Frame end marker
    end_pulse_a:
        assert property (tx_frame_end |=> !tx_frame_end) else $error("end pulse too long");
    end_idle_a:
        assert property (tx_frame_end |-> !tx_active) else $error("end pulse in frame");
endmodule

bind mdf_framer mdf_framer_checker #(.PKT_OCTETS(PKT_OCTETS)) mdf_framer_checker_inst (.clk(clk),
    .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .tx_data(tx_data), .tx_active(tx_active), .tx_frame_end(tx_frame_end));

// >>> dv/mdf_radio_model.sv
`timescale 1ns/10ps
module mdf_radio_model #(
    parameter int HOP_PER  = 300,
    parameter int BIT_CLKS = 4
)
(
    // Clock and capture clear
    input  wire logic         clk,
    input  wire logic         clr,
    // Framer link
    input  wire logic         tx_data,
    input  wire logic         tx_active,
    output logic              hop_sync,
    // Observations
    output int                hop_cnt,
    output logic [127:0]      rx_bits,
    output int                rx_len
);
    int ph;
    int bc;

    initial hop_sync = 1'b0;

    // Free running hops, four clock pulse each
    always @(posedge clk)
    begin
        ph <= (ph == HOP_PER - 1) ? 0 : ph + 1;
        hop_sync <= (ph < 4);
        if (ph == 0)
            hop_cnt <= hop_cnt + 1;
    end

    // Line bits sampled mid-bit while a frame is on air
    always @(posedge clk)
    begin
        if (clr)
        begin
            rx_len <= 0;
            rx_bits <= '0;
        end
        else if (!tx_active)
            bc <= 0;
        else
        begin
            bc <= bc + 1;
            if (bc % BIT_CLKS == BIT_CLKS / 2)
            begin
                rx_bits[rx_len] <= tx_data;
                rx_len <= rx_len + 1;
            end
        end
    end
endmodule

// >>> dv/tb_mdf_framer.sv
`timescale 1ns/10ps
module tb_mdf_framer;
    import mdf_pkg::*;

    localparam int LIM = 2000;
    logic         clk, reset, psel, penable, pwrite, pready, pslverr, e, clr;
    logic         hop_sync, rx_last_bit, rx_multidwell, tx_data, tx_active, tx_frame_end;
    logic [7:0]   paddr;
    logic [31:0]  pwdata, prdata, r, t;
    logic [127:0] rx_bits;
    int           hop_cnt, rx_len, bad_count, cmp_count;

    mdf_framer #(.PKT_OCTETS(1)) mdf_framer_inst (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .hop_sync(hop_sync), .rx_last_bit(rx_last_bit), .rx_multidwell(rx_multidwell), .tx_data(tx_data),
        .tx_active(tx_active), .tx_frame_end(tx_frame_end));
    mdf_radio_model #(.HOP_PER(300), .BIT_CLKS(4)) mdf_radio_model_inst (.clk(clk), .clr(clr),
        .tx_data(tx_data), .tx_active(tx_active), .hop_sync(hop_sync), .hop_cnt(hop_cnt), .rx_bits(rx_bits),
        .rx_len(rx_len));

    always #20 clk = ~clk;

    task automatic conclude();
        $display("Checks %0d, mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic guard(input int n);
        if (n >= LIM)
        begin
            bad_count++;
            conclude();
        end
    endtask

    task automatic chk(input logic [79:0] seen, input logic [79:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("wrong value at %0t: got %0h, expected %0h", $time, seen, exp);
        end
    endtask

    // One APB transfer; read data and error land in r and e
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pready !== 1'b1 && n < LIM);
        guard(n);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Reset values, unmapped access, dwell class and hold delay
    task automatic test_regs();
        apb(1'b0, REG_BAUD, 32'h0);
        chk(r, BAUD_RST);
        apb(1'b0, REG_DWELL, 32'h0);
        chk(r, DWELL_RST);
        apb(1'b0, 8'h40, 32'h0);
        chk(e, 1'b1);
        apb(1'b1, REG_BAUD, 32'h3);
        apb(1'b1, REG_HOLD_BASE, 32'h100);
        apb(1'b1, REG_ACK_INFL, 32'h20);
        apb(1'b1, REG_DWELL, 32'hFF);
        apb(1'b0, REG_STATUS, 32'h0);
        chk(r[7:0] & 8'h82, 8'h02);
        apb(1'b0, REG_HOLD_EFF, 32'h0);
        chk(r, 32'h120);
        apb(1'b1, REG_DWELL, 32'h100);
        apb(1'b0, REG_STATUS, 32'h0);
        chk(r[7:0] & 8'h82, 8'h80);
        apb(1'b0, REG_HOLD_EFF, 32'h0);
        chk(r, 32'h100);
        apb(1'b1, REG_DWELL, 32'h0);
    endtask

    // One single-octet frame: layout, hop alignment, timeout reference
    task automatic test_frame(input logic [2:0] c, input int len, input int hops);
        int n, h0;
        clr <= 1'b1;
        apb(1'b1, REG_TXDATA, 32'h1A5);
        clr <= 1'b0;
        for (n = 0; n < LIM && hop_sync !== 1'b1; n++)
            @(posedge clk);
        guard(n);
        for (n = 0; n < LIM && hop_sync !== 1'b0; n++)
            @(posedge clk);
        guard(n);
        h0 = hop_cnt;
        apb(1'b1, REG_CTRL, {28'h0, 1'b1, c});
        for (n = 0; n < LIM && tx_active !== 1'b1; n++)
            @(posedge clk);
        guard(n);
        chk(hop_cnt - h0, hops);
        for (n = 0; n < LIM && tx_frame_end !== 1'b1; n++)
            @(posedge clk);
        guard(n);
        apb(1'b0, REG_TMO_REF, 32'h0);
        t = r;
        apb(1'b0, REG_TIME, 32'h0);
        chk(r - t < 32'h10, 1'b1);
        chk(rx_len, len);
        chk(rx_bits[23:0], {5'h0, c, SYNC_PAT});
        chk(rx_bits[len-1 -: 8], END_FLAG);
        if (c == 3'h0)
            chk(rx_bits[31:24], 8'hA5);
        if (c == 3'h1)
            chk(rx_bits[62:24], {8'hA5, 15'h0, HEAD_PAT});
        if (c == 3'h2)
            chk(rx_bits[31:24], 8'hD5);
    endtask

    // Multi-dwell reception gets its last bit time tagged
    task automatic test_rx();
        rx_multidwell <= 1'b1;
        rx_last_bit <= 1'b1;
        apb(1'b0, REG_TIME, 32'h0);
        t = r;
        apb(1'b0, REG_RX_TAG, 32'h0);
        apb(1'b0, REG_STATUS, 32'h0);
        chk(r[5:4], 2'h3);
        apb(1'b0, REG_RX_TAG, 32'h0);
        chk(r - t + 32'h8 < 32'h10, 1'b1);
        rx_last_bit <= 1'b0;
        apb(1'b1, REG_STATUS, 32'h10);
        apb(1'b0, REG_STATUS, 32'h0);
        chk(r[4], 1'b0);
    endtask

    // Main sequence
    initial
    begin
        clk = 1'b0;
        reset = 1'b1;
        {psel, penable, pwrite, clr, rx_last_bit, rx_multidwell} = 6'h0;
        paddr = 8'h0;
        pwdata = 32'h0;
        repeat (6) @(posedge clk);
        reset <= 1'b0;
        test_regs();
        test_frame(3'h0, 40, 1);
        test_frame(3'h1, 71, 1);
        test_frame(3'h2, 40, 1);
        test_frame(3'h4, 48, 1);
        apb(1'b1, REG_DWELL, 32'h100);
        test_frame(3'h0, 40, 2);
        test_rx();
        conclude();
    end
endmodule

// >>> verilog/mdf_bch15.sv
`timescale 1ns/10ps
module mdf_bch15
    import mdf_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        reset,
    // Counter in, code word out
    input  wire logic [6:0]  seg_i,
    output logic      [14:0] code_o
);
    // Systematic BCH(15,7): message in high bits, remainder below
    function automatic logic [14:0] bch_encode(input logic [6:0] m);
        logic [14:0] r;
        r = {m, 8'h00};
        for (int i = 14; i >= 8; i--)
        begin
            if (r[i])
            begin
                r[i -: 9] = r[i -: 9] ^ BCH_POLY;
            end
        end
        bch_encode = {m, r[7:0]};
    endfunction

    // Registered code word, follows the counter by one cycle
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            code_o <= 15'h0000;
        end
        else
        begin
            code_o <= bch_encode(seg_i);
        end
    end
endmodule

// >>> verilog/mdf_framer.sv
// How it works
// - Dwell length setting decides long dwell, hence the acknowledgment method.
// - Transmission starts on the first hop after the guaranteed long dwell.
// - Arrival time of the last received bit is captured as timer reference.
// - Multi-dwell receptions get a timestamp at their final bit.
// - Transmit start follows detected or predicted radio hops.
// - Multi-dwell adds a worst-case inflation to the response hold delay.
// - Timeout sync point is taken at the end of the final frame flag.
// - Data octets leave least significant bit first.
// - Multi-dwell frames carry the sync and format fields.
// - Scrambling and coding apply to user data only when selected.
// - Multi-dwell data goes into packets with pattern and coded counter.
// - Without multi-dwell, no packets; sync, format, processed data and end flag only.
//
// Added by the designer: the register offsets and the APB register port.
`timescale 1ns/10ps
module mdf_framer
    import mdf_pkg::*;
#(
    parameter int PKT_OCTETS = 8
)
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        reset,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Radio side, asynchronous pins
    input  wire logic        hop_sync,
    input  wire logic        rx_last_bit,
    input  wire logic        rx_multidwell,
    // Radio side, transmit
    output logic             tx_data,
    output logic             tx_active,
    output logic             tx_frame_end
);
    mdf_state_t  state_q;
    logic        md_q;
    logic        scr_q;
    logic        fec_q;
    logic        go;
    logic [15:0] dwell_q;
    logic [15:0] baud_q;
    logic [31:0] hold_base_q;
    logic [31:0] ack_infl_q;
    logic [31:0] hold_eff;
    logic        long_dwell;
    logic        ack_md;
    logic [7:0]  txd_q;
    logic        txd_last_q;
    logic        txd_full_q;
    logic        done_q;
    logic        under_q;
    logic        rxtag_q;
    logic        rxmd_q;
    logic [31:0] time_q;
    logic [31:0] rx_tag_q;
    logic [31:0] tmo_ref_q;
    logic [2:0]  hop_s_q;
    logic [2:0]  rxl_s_q;
    logic [1:0]  rxm_s_q;
    logic        hop_edge;
    logic        rx_end;
    logic [31:0] hop_cnt_q;
    logic [31:0] hop_per_q;
    logic [31:0] hop_gap_q;
    logic        hop_tick;
    logic [15:0] div_q;
    logic        bit_en;
    logic [15:0] sh_q;
    logic [4:0]  cnt_q;
    logic        phase_q;
    logic        last_q;
    logic [6:0]  seg_q;
    logic [7:0]  pkt_q;
    logic [14:0] seg_code;
    logic        enc_bit;
    logic        cur_bit;
    logic        sending;
    logic        half;
    logic        fld_end;
    logic        fetch;
    logic        frame_done;
    logic        wr;
    logic        setup;
    logic        known;
    logic [31:0] rd_d;

    // Shared field length lookup for the active state
    function automatic logic [4:0] fld_len(input mdf_state_t s);
        case (s)
            ST_SYNC: fld_len = SYNC_LEN;
            ST_FMT:  fld_len = FMT_LEN;
            ST_HEAD: fld_len = HEAD_LEN;
            ST_SEGC: fld_len = SEGC_LEN;
            ST_ENDF: fld_len = ENDF_LEN;
            default: fld_len = OCT_LEN;
        endcase
    endfunction

    // Bus strobes, zero wait states
    assign setup  = psel & ~penable;
    assign wr     = psel & penable & pwrite;
    assign pready = 1'b1;
    assign go     = wr && paddr == REG_CTRL && pwdata[CTRL_GO] && state_q == ST_IDLE;

    // Long dwell decision and acknowledgment method
    assign long_dwell = dwell_q >= LONG_DWELL_MIN;
    assign ack_md     = ~long_dwell;
    // Effective hold delay grows for multi-dwell acknowledgments
    assign hold_eff   = hold_base_q + (ack_md ? ack_infl_q : 32'h0000_0000);

    // Software writable configuration
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            md_q       <= 1'b0;
            scr_q      <= 1'b0;
            fec_q      <= 1'b0;
            dwell_q    <= DWELL_RST;
            baud_q     <= BAUD_RST;
            hold_base_q <= HOLD_RST;
            ack_infl_q <= ACK_INFL_RST;
        end
        else if (wr)
        begin
            if (paddr == REG_CTRL && state_q == ST_IDLE)
            begin
                md_q  <= pwdata[CTRL_MD];
                scr_q <= pwdata[CTRL_SCR];
                fec_q <= pwdata[CTRL_FEC];
            end
            else if (paddr == REG_DWELL)
                dwell_q <= pwdata[15:0];
            else if (paddr == REG_BAUD)
                baud_q <= pwdata[15:0];
            else if (paddr == REG_HOLD_BASE)
                hold_base_q <= pwdata;
            else if (paddr == REG_ACK_INFL)
                ack_infl_q <= pwdata;
        end
    end

    // Read data prepared in the setup phase
    always_comb
    begin
        known = 1'b1;
        rd_d  = 32'h0000_0000;
        if (paddr == REG_CTRL)
            rd_d = {29'h0, fec_q, scr_q, md_q};
        else if (paddr == REG_DWELL)
            rd_d = {16'h0000, dwell_q};
        else if (paddr == REG_BAUD)
            rd_d = {16'h0000, baud_q};
        else if (paddr == REG_HOLD_BASE)
            rd_d = hold_base_q;
        else if (paddr == REG_HOLD_EFF)
            rd_d = hold_eff;
        else if (paddr == REG_STATUS)
            rd_d = {24'h0, long_dwell, txd_full_q, rxmd_q, rxtag_q, under_q, done_q, ack_md, sending};
        else if (paddr == REG_TXDATA)
            rd_d = 32'h0000_0000;
        else if (paddr == REG_RX_TAG)
            rd_d = rx_tag_q;
        else if (paddr == REG_TMO_REF)
            rd_d = tmo_ref_q;
        else if (paddr == REG_TIME)
            rd_d = time_q;
        else if (paddr == REG_ACK_INFL)
            rd_d = ack_infl_q;
        else
            known = 1'b0;
    end

    // Registered read data and error answer
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
        else if (setup)
        begin
            prdata  <= pwrite ? 32'h0000_0000 : rd_d;
            pslverr <= ~known;
        end
    end

    // Transmit octet holding register, writes refused while full
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            txd_q      <= 8'h00;
            txd_last_q <= 1'b0;
            txd_full_q <= 1'b0;
        end
        else if (fetch)
            txd_full_q <= 1'b0;
        else if (wr && paddr == REG_TXDATA && !txd_full_q)
        begin
            txd_q      <= pwdata[7:0];
            txd_last_q <= pwdata[TXD_LAST];
            txd_full_q <= 1'b1;
        end
    end

    // Sticky flags, a set beats a clear in the same cycle
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            done_q  <= 1'b0;
            under_q <= 1'b0;
            rxtag_q <= 1'b0;
        end
        else
        begin
            done_q  <= frame_done | (done_q & ~(wr && paddr == REG_STATUS && pwdata[ST_TXDONE]));
            under_q <= (fld_end && fetch == 1'b0 && state_q == ST_DATA && !last_q && !txd_full_q
                        && !(md_q && pkt_q == 8'(PKT_OCTETS - 1)))
                       | (fld_end && state_q inside {ST_FMT, ST_SEGC} && !txd_full_q)
                       | (under_q & ~(wr && paddr == REG_STATUS && pwdata[ST_UNDER]));
            rxtag_q <= rx_end | (rxtag_q & ~(wr && paddr == REG_STATUS && pwdata[ST_RXTAG]));
        end
    end

    // Pin synchronisers, third stage only for edge detection
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            hop_s_q <= 3'h0;
            rxl_s_q <= 3'h0;
            rxm_s_q <= 2'h0;
        end
        else
        begin
            hop_s_q <= {hop_s_q[1:0], hop_sync};
            rxl_s_q <= {rxl_s_q[1:0], rx_last_bit};
            rxm_s_q <= {rxm_s_q[0], rx_multidwell};
        end
    end

    assign hop_edge = hop_s_q[1] & ~hop_s_q[2];
    assign rx_end   = rxl_s_q[1] & ~rxl_s_q[2];

    // Free running time base
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            time_q <= 32'h0000_0000;
        else
            time_q <= time_q + 32'h0000_0001;
    end

    // Receive reference: time of the last bit, multi-dwell marked
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            rx_tag_q <= 32'h0000_0000;
            rxmd_q   <= 1'b0;
        end
        else if (rx_end)
        begin
            rx_tag_q <= time_q;
            rxmd_q   <= rxm_s_q[1];
        end
    end

    // Hop detection, prediction from the last edge to edge period only
    assign hop_tick = hop_edge | (hop_per_q != 32'h0 && hop_cnt_q == hop_per_q);
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            hop_cnt_q <= 32'h0000_0000;
        else if (hop_tick)
            hop_cnt_q <= 32'h0000_0001;
        else
            hop_cnt_q <= hop_cnt_q + 32'h0000_0001;
    end

    // Edge spacing, zero until a first edge was seen
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            hop_gap_q <= 32'h0000_0000;
            hop_per_q <= 32'h0000_0000;
        end
        else if (hop_edge)
        begin
            hop_gap_q <= 32'h0000_0001;
            hop_per_q <= hop_gap_q;
        end
        else if (hop_gap_q != 32'h0)
            hop_gap_q <= hop_gap_q + 32'h0000_0001;
    end

    // Bit rate divider
    assign bit_en = div_q == 16'h0000;
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            div_q <= BAUD_RST;
        else if (bit_en || state_q == ST_IDLE)
            div_q <= baud_q;
        else
            div_q <= div_q - 16'h0001;
    end

    // Per-bit selection of the outgoing symbol
    assign sending = state_q != ST_IDLE;
    assign half    = state_q == ST_DATA && fec_q && !phase_q;
    assign fld_end = bit_en && !half && cnt_q == fld_len(state_q) - 5'h01
                     && state_q inside {ST_SYNC, ST_FMT, ST_HEAD, ST_SEGC, ST_DATA, ST_ENDF};
    assign fetch   = fld_end && txd_full_q && (state_q == ST_FMT && !md_q || state_q == ST_SEGC
                     || state_q == ST_DATA && !last_q && !(md_q && pkt_q == 8'(PKT_OCTETS - 1)));
    assign cur_bit = state_q == ST_DATA ? enc_bit : sh_q[0];
    assign frame_done = bit_en && state_q == ST_DONE;

    mdf_scrfec mdf_scrfec_inst (
        .clk    (clk),
        .reset  (reset),
        .init   (go),
        .step   (bit_en && state_q == ST_DATA && !half),
        .scr_en (scr_q),
        .fec_en (fec_q),
        .phase  (phase_q),
        .bit_i  (sh_q[0]),
        .bit_o  (enc_bit)
    );

    mdf_bch15 mdf_bch15_inst (
        .clk    (clk),
        .reset  (reset),
        .seg_i  (seg_q),
        .code_o (seg_code)
    );

    // Frame sequencer: hop wait, then contiguous fields
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            state_q <= ST_IDLE;
            sh_q    <= 16'h0000;
            cnt_q   <= 5'h00;
            phase_q <= 1'b0;
            last_q  <= 1'b0;
            seg_q   <= 7'h00;
            pkt_q   <= 8'h00;
        end
        else
        begin
            case (state_q)
                ST_IDLE:
                    if (go)
                    begin
                        state_q <= ST_WAIT_HOP;
                        seg_q   <= 7'h00;
                        last_q  <= 1'b0;
                    end
                ST_WAIT_HOP:
                    if (hop_tick)
                        state_q <= long_dwell ? ST_WAIT_NEXT : ST_SYNC;
                ST_WAIT_NEXT:
                    if (hop_tick)
                        state_q <= ST_SYNC;
                ST_DONE:
                    if (bit_en)
                        state_q <= ST_IDLE;
                default:
                    if (bit_en)
                    begin
                        if (half)
                            phase_q <= 1'b1;
                        else
                        begin
                            phase_q <= 1'b0;
                            sh_q    <= {1'b0, sh_q[15:1]};
                            cnt_q   <= cnt_q + 5'h01;
                        end
                    end
            endcase
            if (state_q == ST_WAIT_HOP || state_q == ST_WAIT_NEXT)
            begin
                sh_q  <= SYNC_PAT;
                cnt_q <= 5'h00;
            end
            if (fld_end)
            begin
                cnt_q <= 5'h00;
                if (fetch)
                begin
                    state_q <= ST_DATA;
                    sh_q    <= {8'h00, txd_q};
                    last_q  <= txd_last_q;
                    if (state_q == ST_DATA)
                        pkt_q <= pkt_q + 8'h01;
                    else
                        pkt_q <= 8'h00;
                end
                else if (state_q == ST_SYNC)
                begin
                    state_q <= ST_FMT;
                    sh_q    <= {13'h0000, fec_q, scr_q, md_q};
                end
                else if (state_q == ST_FMT && md_q || state_q == ST_DATA && md_q && !last_q
                         && pkt_q == 8'(PKT_OCTETS - 1))
                begin
                    state_q <= ST_HEAD;
                    sh_q    <= HEAD_PAT;
                end
                else if (state_q == ST_HEAD)
                begin
                    state_q <= ST_SEGC;
                    sh_q    <= {1'b0, seg_code};
                    seg_q   <= seg_q + 7'h01;
                end
                else if (state_q == ST_ENDF)
                    state_q <= ST_DONE;
                else
                begin
                    state_q <= ST_ENDF;
                    sh_q    <= {8'h00, END_FLAG};
                end
            end
        end
    end

    // Registered line outputs
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            tx_data      <= 1'b0;
            tx_active    <= 1'b0;
            tx_frame_end <= 1'b0;
        end
        else
        begin
            tx_frame_end <= frame_done;
            if (bit_en)
                tx_data <= state_q inside {ST_SYNC, ST_FMT, ST_HEAD, ST_SEGC, ST_DATA, ST_ENDF} & cur_bit;
            if (bit_en)
                tx_active <= state_q inside {ST_SYNC, ST_FMT, ST_HEAD, ST_SEGC, ST_DATA, ST_ENDF};
        end
    end

    // Timeout sync point at the end of the final flag
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            tmo_ref_q <= 32'h0000_0000;
        else if (frame_done)
            tmo_ref_q <= time_q;
    end
endmodule

// >>> verilog/mdf_pkg.sv
package mdf_pkg;
    // Register byte offsets
    localparam logic [7:0] REG_CTRL     = 8'h00;
    localparam logic [7:0] REG_DWELL    = 8'h04;
    localparam logic [7:0] REG_BAUD     = 8'h08;
    localparam logic [7:0] REG_HOLD_BASE = 8'h0C;
    localparam logic [7:0] REG_HOLD_EFF  = 8'h10;
    localparam logic [7:0] REG_STATUS   = 8'h14;
    localparam logic [7:0] REG_TXDATA   = 8'h18;
    localparam logic [7:0] REG_RX_TAG   = 8'h1C;
    localparam logic [7:0] REG_TMO_REF  = 8'h20;
    localparam logic [7:0] REG_TIME     = 8'h24;
    localparam logic [7:0] REG_ACK_INFL = 8'h28;

    // Control and status bit positions
    localparam int CTRL_MD    = 0;
    localparam int CTRL_SCR   = 1;
    localparam int CTRL_FEC   = 2;
    localparam int CTRL_GO    = 3;
    localparam int TXD_LAST   = 8;
    localparam int ST_BUSY    = 0;
    localparam int ST_ACK_MD  = 1;
    localparam int ST_TXDONE  = 2;
    localparam int ST_UNDER   = 3;
    localparam int ST_RXTAG   = 4;
    localparam int ST_RXMD    = 5;
    localparam int ST_TXFULL  = 6;
    localparam int ST_LONG    = 7;

    // Reset values
    localparam logic [15:0] DWELL_RST    = 16'h0000;
    localparam logic [15:0] BAUD_RST     = 16'h0A2C;
    localparam logic [31:0] HOLD_RST     = 32'h0000_0000;
    localparam logic [31:0] ACK_INFL_RST = 32'h0000_0000;
    localparam logic [15:0] LONG_DWELL_MIN = 16'h0100;

    // Field lengths in bits and field contents
    localparam logic [4:0]  SYNC_LEN = 5'h10;
    localparam logic [4:0]  FMT_LEN  = 5'h08;
    localparam logic [4:0]  HEAD_LEN = 5'h10;
    localparam logic [4:0]  SEGC_LEN = 5'h0F;
    localparam logic [4:0]  OCT_LEN  = 5'h08;
    localparam logic [4:0]  ENDF_LEN = 5'h08;
    localparam logic [15:0] SYNC_PAT = 16'hEB90;
    localparam logic [15:0] HEAD_PAT = 16'h1ACF;
    localparam logic [7:0]  END_FLAG = 8'h7E;
    localparam logic [6:0]  SCR_SEED = 7'h7F;
    localparam logic [8:0]  BCH_POLY = 9'h1D1;

    // Transmit sequencer, Gray coded along the frame path
    typedef enum logic [3:0] {
        ST_IDLE      = 4'h0,
        ST_WAIT_HOP  = 4'h1,
        ST_WAIT_NEXT = 4'h3,
        ST_SYNC      = 4'h2,
        ST_FMT       = 4'h6,
        ST_HEAD      = 4'h7,
        ST_SEGC      = 4'h5,
        ST_DATA      = 4'h4,
        ST_ENDF      = 4'hC,
        ST_DONE      = 4'hD
    } mdf_state_t;
endpackage

// >>> verilog/mdf_scrfec.sv
`timescale 1ns/10ps
module mdf_scrfec
    import mdf_pkg::*;
(
    // Clock and reset
    input  wire logic clk,
    input  wire logic reset,
    // Control
    input  wire logic init,
    input  wire logic step,
    input  wire logic scr_en,
    input  wire logic fec_en,
    input  wire logic phase,
    // Data
    input  wire logic bit_i,
    output logic      bit_o
);
    logic [6:0] lfsr_q;
    logic [1:0] mem_q;
    logic       s;

    // Additive scrambler, then rate 1/2 coder (generators 7 and 5)
    always_comb
    begin
        s = bit_i ^ (scr_en & (lfsr_q[6] ^ lfsr_q[3]));
        if (!fec_en)
            bit_o = s;
        else if (phase)
            bit_o = s ^ mem_q[1];
        else
            bit_o = s ^ mem_q[0] ^ mem_q[1];
    end

    // State advances once per consumed data bit
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            lfsr_q <= SCR_SEED;
            mem_q  <= 2'h0;
        end
        else if (init)
        begin
            lfsr_q <= SCR_SEED;
            mem_q  <= 2'h0;
        end
        else if (step)
        begin
            lfsr_q <= {lfsr_q[5:0], lfsr_q[6] ^ lfsr_q[3]};
            mem_q  <= {mem_q[0], s};
        end
    end
endmodule
